/* pcj_load_model.sv */
// Purpose: Load model on the modulator pins, counts high cycles per pin
// Assumes: Pins are sampled on the rising clock edge
// Notes: Count clears while gate is low, so each window starts from zero
`timescale 1ns/1ps
`default_nettype none

module pcj_load_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and window
  input wire logic gate,
  input wire logic [7:0] pins,
  output logic [7:0][15:0] high_cnt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt <= '0;
    end else if (!gate) begin
      high_cnt <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        high_cnt[i] <= high_cnt[i] + 16'(pins[i]);
      end
    end
  end
endmodule : pcj_load_model

`default_nettype wire

/* pcj_pair.sv */
// Purpose: Shared constants and one channel pair of the modulator, split or joined
// Assumes: Clock ticks arrive already selected per channel, one cycle wide
// Notes: A joined pair counts as one 16-bit channel; even byte is the high byte
`timescale 1ns/1ps
`default_nettype none

package pcj_pkg;
  localparam int PCJ_CHANNELS = 8;
  localparam int PCJ_PAIRS = 4;
  localparam int PCJ_WIDTH = 8;
  // Register byte offsets
  localparam logic [7:0] PCJ_CTRL_OFS = 8'h00;
  localparam logic [7:0] PCJ_ENABLE_OFS = 8'h04;
  localparam logic [7:0] PCJ_POL_OFS = 8'h08;
  localparam logic [7:0] PCJ_CLKSEL_OFS = 8'h0c;
  localparam logic [7:0] PCJ_PRESCALE_OFS = 8'h10;
  localparam logic [7:0] PCJ_STATUS_OFS = 8'h14;
  localparam logic [2:0] PCJ_PERIOD_REGION = 3'h1;
  localparam logic [2:0] PCJ_DUTY_REGION = 3'h2;
  localparam logic [2:0] PCJ_COUNT_REGION = 3'h3;
  // Field positions
  localparam int PCJ_CH_IDX_LSB = 2;
  localparam int PCJ_REGION_LSB = 5;
  localparam int PCJ_PRE_B_LSB = 8;
  // Reset values
  localparam logic [7:0] PCJ_PERIOD_RST = 8'hff;
  localparam logic [7:0] PCJ_DUTY_RST = 8'h00;
  localparam logic [7:0] PCJ_ZERO8 = 8'h00;
  localparam logic [15:0] PCJ_ZERO16 = 16'h0000;

  typedef struct packed {
    logic [7:0] cnt_e;
    logic [7:0] cnt_o;
    logic [1:0] wave;
  } pcj_pair_state_type;
endpackage : pcj_pkg

module pcj_pair (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pair configuration
  input wire logic join_en,
  input wire logic [1:0] ch_en,
  input wire logic [1:0] ch_pol,
  input wire logic [1:0] ch_tick,
  input wire logic [1:0] ch_clr,
  input wire logic [7:0] per_e,
  input wire logic [7:0] per_o,
  input wire logic [7:0] dty_e,
  input wire logic [7:0] dty_o,
  // Pair state
  output logic [7:0] cnt_e,
  output logic [7:0] cnt_o,
  output logic [1:0] wave
);
  pcj_pkg::pcj_pair_state_type s_reg;
  pcj_pkg::pcj_pair_state_type s_next;
  logic [15:0] c16;
  logic [15:0] p16;
  logic [15:0] d16;
  logic end16;
  logic lt16;

  function automatic logic [7:0] step8(input logic [7:0] cnt, input logic [7:0] per,
                                       input logic en, input logic tick, input logic clr);
    logic [7:0] r;
    r = cnt;
    if (!en || clr) begin
      r = pcj_pkg::PCJ_ZERO8;
    end else if (tick) begin
      // A zero period parks the counter at zero
      if (per == pcj_pkg::PCJ_ZERO8 || cnt >= per - 8'h01) begin
        r = pcj_pkg::PCJ_ZERO8;
      end else begin
        r = cnt + 8'h01;
      end
    end
    return r;
  endfunction : step8

  assign c16 = {s_reg.cnt_e, s_reg.cnt_o};
  assign p16 = {per_e, per_o};
  assign d16 = {dty_e, dty_o};
  assign end16 = (p16 == pcj_pkg::PCJ_ZERO16) || (c16 >= p16 - 16'h0001);
  assign lt16 = c16 < d16;

  always_comb begin
    s_next = s_reg;
    if (join_en) begin
      // Odd channel enable, clock and polarity govern the joined channel
      if (!ch_en[1] || (|ch_clr)) begin
        {s_next.cnt_e, s_next.cnt_o} = pcj_pkg::PCJ_ZERO16;
      end else if (ch_tick[1]) begin
        {s_next.cnt_e, s_next.cnt_o} = end16 ? pcj_pkg::PCJ_ZERO16 : c16 + 16'h0001;
      end
      s_next.wave[0] = 1'b0;
      s_next.wave[1] = ch_en[1] & (lt16 ^ ~ch_pol[1]);
    end else begin
      s_next.cnt_e = step8(s_reg.cnt_e, per_e, ch_en[0], ch_tick[0], ch_clr[0]);
      s_next.cnt_o = step8(s_reg.cnt_o, per_o, ch_en[1], ch_tick[1], ch_clr[1]);
      s_next.wave[0] = ch_en[0] & ((s_reg.cnt_e < dty_e) ^ ~ch_pol[0]);
      s_next.wave[1] = ch_en[1] & ((s_reg.cnt_o < dty_o) ^ ~ch_pol[1]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cnt_e = s_reg.cnt_e;
  assign cnt_o = s_reg.cnt_o;
  assign wave = s_reg.wave;

  a_join_even_low: assert property (@(posedge pclk) disable iff (!presetn)
    $past(join_en) |-> !wave[0]) else $error("even pin active while joined");

  a_join_odd_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(join_en) && $past(ch_en[1])) |-> (wave[1] == ($past(lt16) ^ !$past(ch_pol[1]))))
    else $error("joined output polarity wrong");

  a_join_odd_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (join_en && ch_en[1] && !ch_tick[1] && ch_clr == 2'b00) |=> $stable(c16))
    else $error("joined counter moved without odd tick");

  a_join_byte_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (join_en && ch_en[1] && ch_tick[1] && ch_clr == 2'b00 && c16 == 16'h00ff
     && p16 > 16'h0100) |=> (cnt_e == 8'h01 && cnt_o == 8'h00))
    else $error("low byte did not carry into high byte");

  a_join_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (join_en && ch_en[1] && ch_tick[1] && ch_clr == 2'b00 && per_o != 8'h00
     && c16 == p16 - 16'h0001) ##1 join_en
    |-> (c16 == 16'h0000 && $past(cnt_e) == $past(per_e)))
    else $error("joined period wrap wrong");

  a_split_step: assert property (@(posedge pclk) disable iff (!presetn)
    (!join_en && ch_en[0] && ch_tick[0] && !ch_clr[0] && cnt_e == 8'h00 && per_e > 8'h01)
    |=> cnt_e == 8'h01) else $error("split even counter did not step");
endmodule : pcj_pair

`default_nettype wire

/* pcj_top.sv */
// Functional notes
// - Unit runs each adjacent channel pair as two 8-bit channels or as one joined 16-bit channel.
// - Control register holds four join bits, one per adjacent channel pair.
// - In a joined pair the even channel registers hold the high bytes.
// - A joined channel is clocked by the odd channel clock selection.
// - A joined channel drives its waveform on the odd channel pin.
// - A joined channel output polarity follows the odd channel polarity bit.
//
// Purpose: Eight-channel pulse-width modulator with pairwise channel joining
// Assumes: APB slave, read data captured in the setup phase, no wait states
// Notes: Each channel picks one of two prescaled clocks; counters are left aligned
`timescale 1ns/1ps
`default_nettype none

module pcj_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modulator pins
  output logic [7:0] pwm_out
);
  typedef struct packed {
    logic [3:0] join_bits;
    logic [7:0] ch_en;
    logic [7:0] ch_pol;
    logic [7:0] ch_clksel;
    logic [7:0] pre_a;
    logic [7:0] pre_b;
    logic [7:0] div_a;
    logic [7:0] div_b;
    logic [7:0][7:0] period;
    logic [7:0][7:0] duty;
    logic [31:0] rdata;
  } pcj_top_state_type;

  pcj_top_state_type s_reg;
  pcj_top_state_type s_next;

  logic [7:0] ofs;
  logic [2:0] region;
  logic [2:0] ch_idx;
  logic aligned;
  logic hit_ctrl;
  logic hit_enable;
  logic hit_pol;
  logic hit_clksel;
  logic hit_pre;
  logic hit_status;
  logic hit_period;
  logic hit_duty;
  logic hit_count;
  logic mapped;
  logic wr_access;
  logic rd_setup;
  logic tick_a;
  logic tick_b;
  logic [7:0] ch_tick;
  logic [7:0] ch_clr;
  logic [7:0][7:0] cnt_all;
  logic [7:0] wave_all;

  // Address decode: one aligned word per register
  assign ofs = paddr[7:0];
  assign region = ofs[7:pcj_pkg::PCJ_REGION_LSB];
  assign ch_idx = ofs[pcj_pkg::PCJ_REGION_LSB-1:pcj_pkg::PCJ_CH_IDX_LSB];
  // Upper address bits must be zero, so a wider bus does not alias the map
  assign aligned = (ofs[1:0] == 2'b00) && (paddr == ADDR_W'(ofs));
  assign hit_ctrl = aligned && ofs == pcj_pkg::PCJ_CTRL_OFS;
  assign hit_enable = aligned && ofs == pcj_pkg::PCJ_ENABLE_OFS;
  assign hit_pol = aligned && ofs == pcj_pkg::PCJ_POL_OFS;
  assign hit_clksel = aligned && ofs == pcj_pkg::PCJ_CLKSEL_OFS;
  assign hit_pre = aligned && ofs == pcj_pkg::PCJ_PRESCALE_OFS;
  assign hit_status = aligned && ofs == pcj_pkg::PCJ_STATUS_OFS;
  assign hit_period = aligned && region == pcj_pkg::PCJ_PERIOD_REGION;
  assign hit_duty = aligned && region == pcj_pkg::PCJ_DUTY_REGION;
  assign hit_count = aligned && region == pcj_pkg::PCJ_COUNT_REGION;
  assign mapped = hit_ctrl | hit_enable | hit_pol | hit_clksel | hit_pre | hit_status
                | hit_period | hit_duty | hit_count;

  assign wr_access = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;

  // Zero wait states; read data was latched in the setup cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata = s_reg.rdata;

  // Prescalers give one-cycle enables every pre+1 clocks
  assign tick_a = (s_reg.div_a == s_reg.pre_a);
  assign tick_b = (s_reg.div_b == s_reg.pre_b);

  // Writing a counter word restarts that channel; for a joined pair either word does
  genvar gi;
  generate
    for (gi = 0; gi < pcj_pkg::PCJ_CHANNELS; gi++) begin : g_ch
      assign ch_tick[gi] = s_reg.ch_clksel[gi] ? tick_b : tick_a;
      assign ch_clr[gi] = wr_access && hit_count && (ch_idx == 3'(gi));
    end
    for (gi = 0; gi < pcj_pkg::PCJ_PAIRS; gi++) begin : g_pair
      pcj_pair u_pair (
        .pclk(pclk),
        .presetn(presetn),
        .join_en(s_reg.join_bits[gi]),
        .ch_en(s_reg.ch_en[2*gi+1:2*gi]),
        .ch_pol(s_reg.ch_pol[2*gi+1:2*gi]),
        .ch_tick(ch_tick[2*gi+1:2*gi]),
        .ch_clr(ch_clr[2*gi+1:2*gi]),
        .per_e(s_reg.period[2*gi]),
        .per_o(s_reg.period[2*gi+1]),
        .dty_e(s_reg.duty[2*gi]),
        .dty_o(s_reg.duty[2*gi+1]),
        .cnt_e(cnt_all[2*gi]),
        .cnt_o(cnt_all[2*gi+1]),
        .wave(wave_all[2*gi+1:2*gi])
      );
    end
  endgenerate

  assign pwm_out = wave_all;

  always_comb begin
    s_next = s_reg;
    s_next.div_a = tick_a ? pcj_pkg::PCJ_ZERO8 : s_reg.div_a + 8'h01;
    s_next.div_b = tick_b ? pcj_pkg::PCJ_ZERO8 : s_reg.div_b + 8'h01;
    // A lowered prescale value must not strand the divider above it
    if (s_reg.div_a > s_reg.pre_a) begin
      s_next.div_a = pcj_pkg::PCJ_ZERO8;
    end
    if (s_reg.div_b > s_reg.pre_b) begin
      s_next.div_b = pcj_pkg::PCJ_ZERO8;
    end
    if (wr_access) begin
      if (hit_ctrl) begin
        // Join bits are taken as written; software keeps the pair idle meanwhile
        s_next.join_bits = pwdata[pcj_pkg::PCJ_PAIRS-1:0];
      end
      if (hit_enable) begin
        s_next.ch_en = pwdata[7:0];
      end
      if (hit_pol) begin
        s_next.ch_pol = pwdata[7:0];
      end
      if (hit_clksel) begin
        s_next.ch_clksel = pwdata[7:0];
      end
      if (hit_pre) begin
        s_next.pre_a = pwdata[7:0];
        s_next.pre_b = pwdata[pcj_pkg::PCJ_PRE_B_LSB+7:pcj_pkg::PCJ_PRE_B_LSB];
      end
      if (hit_period) begin
        s_next.period[ch_idx] = pwdata[7:0];
      end
      if (hit_duty) begin
        s_next.duty[ch_idx] = pwdata[7:0];
      end
    end
    if (rd_setup) begin
      s_next.rdata = 32'h0000_0000;
      if (hit_ctrl) begin
        s_next.rdata[pcj_pkg::PCJ_PAIRS-1:0] = s_reg.join_bits;
      end
      if (hit_enable) begin
        s_next.rdata[7:0] = s_reg.ch_en;
      end
      if (hit_pol) begin
        s_next.rdata[7:0] = s_reg.ch_pol;
      end
      if (hit_clksel) begin
        s_next.rdata[7:0] = s_reg.ch_clksel;
      end
      if (hit_pre) begin
        s_next.rdata[15:0] = {s_reg.pre_b, s_reg.pre_a};
      end
      if (hit_status) begin
        s_next.rdata[7:0] = wave_all;
      end
      if (hit_period) begin
        s_next.rdata[7:0] = s_reg.period[ch_idx];
      end
      if (hit_duty) begin
        s_next.rdata[7:0] = s_reg.duty[ch_idx];
      end
      if (hit_count) begin
        s_next.rdata[7:0] = cnt_all[ch_idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.period <= {pcj_pkg::PCJ_CHANNELS{pcj_pkg::PCJ_PERIOD_RST}};
      s_reg.duty <= {pcj_pkg::PCJ_CHANNELS{pcj_pkg::PCJ_DUTY_RST}};
    end else begin
      s_reg <= s_next;
    end
  end

  a_ctrl_join_write: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr[7:0] == pcj_pkg::PCJ_CTRL_OFS)
    |=> s_reg.join_bits == $past(pwdata[3:0]))
    else $error("join bits not loaded from control write");
endmodule : pcj_top

`default_nettype wire

/* tb_pwm_channel_pair_concatenation.sv */
// Purpose: Self-checking bench for pair joining of the modulator
// Assumes: Zero wait APB slave, prescaler A at 0 ticks every cycle
// Notes: Windows span whole periods or a steady pin, so high counts do not depend on phase
`timescale 1ns/1ps
`default_nettype none

module tb_pwm_channel_pair_concatenation;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pwm_out;
  logic gate = 1'b0;
  logic [7:0][15:0] high_cnt;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int checked = 0;

  always #5 pclk = ~pclk;

  pcj_top #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out));
  pcj_load_model load (.pclk(pclk), .presetn(presetn), .gate(gate), .pins(pwm_out),
    .high_cnt(high_cnt));

  task automatic tally_and_finish();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, er}, {31'h0, experr});
  endtask : rdchk

  // Sample point sits between edges so the final count is settled
  task automatic measure(input int cycles);
    repeat (4) @(posedge pclk);
    gate <= 1'b1;
    repeat (cycles) @(posedge pclk);
    gate <= 1'b0;
    #1;
  endtask : measure

  task automatic t_regs();
    rdchk(8'h00, 32'h0, 1'b0);
    rdchk(8'h2c, 32'hff, 1'b0);
    rdchk(8'h18, 32'h0, 1'b1);
    wr(8'h01, 32'h1);
    check({31'h0, er}, 32'h1);
    rdchk(8'h00, 32'h0, 1'b0);
  endtask : t_regs

  task automatic t_join_bits();
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h1 << i);
      rdchk(8'h00, 32'h1 << i, 1'b0);
    end
    wr(8'h00, 32'hff);
    rdchk(8'h00, 32'h0f, 1'b0);
    wr(8'h00, 32'h0);
  endtask : t_join_bits

  task automatic t_split();
    wr(8'h20, 32'h4);
    wr(8'h24, 32'h4);
    wr(8'h40, 32'h1);
    wr(8'h44, 32'h3);
    wr(8'h08, 32'h03);
    wr(8'h04, 32'h03);
    measure(40);
    check({16'h0, high_cnt[0]}, 32'ha);
    check({16'h0, high_cnt[1]}, 32'h1e);
  endtask : t_split

  // Joined period 0x0104, duty 0x0041; split halves would give other counts
  task automatic t_joined(input logic [31:0] pol, input logic [31:0] exp);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h01);
    wr(8'h24, 32'h04);
    wr(8'h40, 32'h00);
    wr(8'h44, 32'h41);
    wr(8'h08, pol);
    wr(8'h04, 32'h03);
    measure(520);
    check({16'h0, high_cnt[1]}, exp);
    check({16'h0, high_cnt[0]}, 32'h0);
  endtask : t_joined

  // Clock B ticks every 256 cycles, so a slow pair stays below its duty
  task automatic t_clk(input logic [31:0] sel, input logic [31:0] exp);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'hff00);
    wr(8'h08, 32'h02);
    wr(8'h0c, sel);
    wr(8'h04, 32'h03);
    measure(520);
    check({16'h0, high_cnt[1]}, exp);
  endtask : t_clk

  // Duty 0 with polarity 0 holds a split pin high; joined pair 3 with its odd channel off stays low
  task automatic t_status();
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h09);
    wr(8'h04, 32'h44);
    rdchk(8'h14, 32'h04, 1'b0);
    #1;
    check({24'h0, pwm_out}, 32'h04);
  endtask : t_status

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_join_bits();
    t_split();
    t_joined(32'h02, 32'h82);
    t_joined(32'h01, 32'h186);
    t_clk(32'h02, 32'h208);
    t_clk(32'h01, 32'h82);
    t_status();
    tally_and_finish();
  end
endmodule : tb_pwm_channel_pair_concatenation

`default_nettype wire
